/* include/cte_pkg.sv */
// Constants and types shared by the T=0 command sequencer
package cte_pkg;
    localparam logic [7:0] CTE_SW1_OK = 8'h90;
    localparam logic [7:0] CTE_SW2_OK = 8'h00;
    localparam logic [7:0] CTE_PB_RELEN = 8'h6c;
    localparam logic [7:0] CTE_PB_MORE = 8'h61;
    localparam logic [7:0] CTE_SW1_WARN = 8'h62;
    localparam logic [7:0] CTE_GR_CLA = 8'h00;
    localparam logic [7:0] CTE_GR_INS = 8'hc0;
    localparam logic [7:0] CTE_GR_PAR = 8'h00;
    localparam logic [7:0] CTE_LEN_ZERO = 8'h00;
    localparam logic [7:0] CTE_BYTE_RST = 8'h00;
    localparam logic [2:0] CTE_HCNT_RST = 3'h0;
    localparam logic [2:0] CTE_HDR_LAST = 3'h4;

    typedef enum logic [1:0] {
        CTE_LIFE_OFF,
        CTE_LIFE_MGMT,
        CTE_LIFE_OPER
    } cte_life_type;

    typedef enum logic [1:0] {
        CTE_ACT_STATUS,
        CTE_ACT_RELEN,
        CTE_ACT_TAKE,
        CTE_ACT_SEND
    } cte_act_type;

    typedef struct packed {
        logic [7:0] cla;
        logic [7:0] ins;
        logic [7:0] p1;
        logic [7:0] p2;
        logic [7:0] p3;
    } cte_hdr_type;

    typedef struct packed {
        logic [7:0] sw1;
        logic [7:0] sw2;
    } cte_sw_type;

    typedef struct packed {
        cte_act_type act;
        cte_sw_type sw;
        logic [7:0] len;
    } cte_ans_type;
endpackage : cte_pkg

/* rtl/cte_sync.sv */
// Two-stage synchroniser for a level from a pin
`timescale 1ns/1ps
module cte_sync (
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_q;
    logic sync_q;

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule : cte_sync

/* rtl/cte_seq.sv */
// T=0 command-response sequencer with card operating states
`timescale 1ns/1ps
// Contract
// - Inactive means powered off; no session and no command handling.
// - Management state reachable from any active state; left once all PINs verified.
// - Operation state entered only after a session activation succeeded.
// - No-data command completes with only the two status bytes.
// - Wrong length gets 6C plus length; resent header gets INS, data, status.
// - Incoming data only after INS echo; then status word returned.
// - Pending response announced as 61 plus count; fetched by GET RESPONSE.
// - GET RESPONSE answered by C0 echo, requested data, then status.
// - Partial fetch ends 61 plus remainder; request never above announced count.
// - Warning 62 after data; zero-length fetch gets 6C with true length.
module cte_seq
    import cte_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_NRST,
    input wire logic I_PWR_ON,
    input wire logic I_SESS_OK,
    input wire logic I_APP_SEL_REQ,
    input wire logic I_PIN_ALL_OK,
    input wire logic I_TRM_VALID,
    input wire logic [7:0] I_TRM_BYTE,
    output logic O_TRM_READY,
    output logic O_CRD_VALID,
    output logic [7:0] O_CRD_BYTE,
    input wire logic I_CRD_READY,
    output logic O_HDR_VALID,
    output cte_hdr_type O_HDR,
    input wire logic I_ANS_VALID,
    input wire cte_ans_type I_ANS,
    output logic O_DAT_VALID,
    output logic [7:0] O_DAT_BYTE,
    output logic [7:0] O_RD_IDX,
    input wire logic [7:0] I_RD_BYTE,
    output cte_life_type O_LIFE,
    output logic [7:0] O_PEND_LEN
);
    typedef enum logic [2:0] {
        ST_HDR, ST_ANS, ST_ECHO, ST_RXD, ST_DONE, ST_TXD, ST_SW1, ST_SW2
    } cte_st_type;

    cte_st_type st_q, st_d, nxt_q, nxt_d;
    cte_life_type life_q, life_d;
    cte_hdr_type hdr_q, hdr_d, hdr_full;
    cte_sw_type sw_q, sw_d;
    logic [2:0] hcnt_q, hcnt_d;
    logic [7:0] cnt_q, cnt_d, idx_q, idx_d, pend_len_q, pend_len_d, pend_off_q, pend_off_d;
    logic [7:0] tx_byte_q, tx_byte_d, dat_q, dat_d;
    logic tx_vld_q, tx_vld_d, hdr_vld_q, hdr_vld_d, dat_vld_q, dat_vld_d;
    logic sess_q, sess_d, pwr_s, go, trm_fire, tx_fire, hdr_last, is_gr, gr_take, gr_relen;

    // Status after command data: warning wins, then pending announce
    function automatic cte_sw_type post_sw(input cte_ans_type a);
        if (a.sw.sw1 == CTE_SW1_WARN) begin
            post_sw = a.sw;
        end else if (a.len != CTE_LEN_ZERO) begin
            post_sw = '{sw1: CTE_PB_MORE, sw2: a.len};
        end else begin
            post_sw = a.sw;
        end
    endfunction : post_sw

    cte_sync u_pwr_sync (
        .i_clk(I_CORE_CLK),
        .i_nrst(I_NRST),
        .i_async(I_PWR_ON),
        .o_sync(pwr_s)
    );

    // Card operating states
    assign life_d = !pwr_s ? CTE_LIFE_OFF :
        (life_q == CTE_LIFE_OFF) ? CTE_LIFE_MGMT :
        I_APP_SEL_REQ ? CTE_LIFE_MGMT :
        (life_q == CTE_LIFE_MGMT && I_PIN_ALL_OK && sess_q) ? CTE_LIFE_OPER :
        life_q;
    assign sess_d = pwr_s && (sess_q || I_SESS_OK);

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST) begin
            life_q <= CTE_LIFE_OFF;
            sess_q <= 1'b0;
        end else begin
            life_q <= life_d;
            sess_q <= sess_d;
        end
    end

    // Handshakes and header decode
    assign O_TRM_READY = (life_q != CTE_LIFE_OFF) && (st_q == ST_HDR || st_q == ST_RXD);
    assign trm_fire = I_TRM_VALID && O_TRM_READY;
    assign tx_fire = tx_vld_q && I_CRD_READY;
    assign hdr_full = {hdr_q[31:0], I_TRM_BYTE};
    assign hdr_last = st_q == ST_HDR && trm_fire && hcnt_q == CTE_HDR_LAST;
    assign is_gr = hdr_full.cla == CTE_GR_CLA && hdr_full.ins == CTE_GR_INS
        && hdr_full.p1 == CTE_GR_PAR && hdr_full.p2 == CTE_GR_PAR;
    assign gr_relen = hdr_full.p3 == CTE_LEN_ZERO || hdr_full.p3 > pend_len_q;
    assign gr_take = hdr_last && is_gr && pend_len_q != CTE_LEN_ZERO;

    always_comb begin
        st_d = st_q;
        nxt_d = nxt_q;
        hdr_d = hdr_q;
        sw_d = sw_q;
        hcnt_d = hcnt_q;
        cnt_d = cnt_q;
        idx_d = idx_q;
        pend_len_d = pend_len_q;
        pend_off_d = pend_off_q;
        tx_vld_d = tx_vld_q;
        tx_byte_d = tx_byte_q;
        dat_d = dat_q;
        hdr_vld_d = 1'b0;
        dat_vld_d = 1'b0;
        go = 1'b0;
        unique case (st_q)
            ST_HDR: begin
                if (trm_fire) begin
                    hdr_d = hdr_full;
                    hcnt_d = hcnt_q + 3'h1;
                    if (hdr_last) begin
                        hcnt_d = CTE_HCNT_RST;
                        go = 1'b1;
                        if (gr_take && gr_relen) begin
                            sw_d = '{sw1: CTE_PB_RELEN, sw2: pend_len_q};
                            st_d = ST_SW1;
                        end else if (gr_take) begin
                            st_d = ST_ECHO;
                            nxt_d = ST_TXD;
                            cnt_d = hdr_full.p3;
                            idx_d = pend_off_q;
                            pend_len_d = pend_len_q - hdr_full.p3;
                            pend_off_d = pend_off_q + hdr_full.p3;
                            if (pend_len_q == hdr_full.p3) begin
                                sw_d = '{sw1: CTE_SW1_OK, sw2: CTE_SW2_OK};
                            end else begin
                                sw_d = '{sw1: CTE_PB_MORE, sw2: pend_len_q - hdr_full.p3};
                            end
                        end else begin
                            pend_len_d = CTE_LEN_ZERO;
                            pend_off_d = CTE_LEN_ZERO;
                            hdr_vld_d = 1'b1;
                            st_d = ST_ANS;
                        end
                    end
                end
            end
            ST_ANS: begin
                if (I_ANS_VALID) begin
                    go = 1'b1;
                    sw_d = I_ANS.sw;
                    cnt_d = hdr_q.p3;
                    idx_d = CTE_LEN_ZERO;
                    unique case (I_ANS.act)
                        CTE_ACT_STATUS: st_d = ST_SW1;
                        CTE_ACT_RELEN: begin
                            sw_d = '{sw1: CTE_PB_RELEN, sw2: I_ANS.len};
                            st_d = ST_SW1;
                        end
                        CTE_ACT_TAKE: begin
                            st_d = ST_ECHO;
                            nxt_d = ST_RXD;
                        end
                        CTE_ACT_SEND: begin
                            st_d = ST_ECHO;
                            nxt_d = ST_TXD;
                        end
                    endcase
                end
            end
            ST_ECHO: begin
                if (tx_fire) begin
                    go = 1'b1;
                    if (cnt_q == CTE_LEN_ZERO) begin
                        st_d = (nxt_q == ST_RXD) ? ST_DONE : ST_SW1;
                    end else begin
                        st_d = nxt_q;
                    end
                end
            end
            ST_RXD: begin
                if (trm_fire) begin
                    dat_vld_d = 1'b1;
                    dat_d = I_TRM_BYTE;
                    cnt_d = cnt_q - 8'h01;
                    if (cnt_q == 8'h01) begin
                        st_d = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                if (I_ANS_VALID) begin
                    go = 1'b1;
                    sw_d = post_sw(I_ANS);
                    st_d = ST_SW1;
                    if (I_ANS.len != CTE_LEN_ZERO) begin
                        pend_len_d = I_ANS.len;
                        pend_off_d = CTE_LEN_ZERO;
                    end
                end
            end
            ST_TXD: begin
                if (!tx_vld_q) begin
                    tx_vld_d = 1'b1;
                    tx_byte_d = I_RD_BYTE;
                end else if (tx_fire) begin
                    tx_vld_d = 1'b0;
                    idx_d = idx_q + 8'h01;
                    cnt_d = cnt_q - 8'h01;
                    if (cnt_q == 8'h01) begin
                        go = 1'b1;
                        st_d = ST_SW1;
                    end
                end
            end
            ST_SW1: begin
                if (tx_fire) begin
                    go = 1'b1;
                    st_d = ST_SW2;
                end
            end
            ST_SW2: begin
                if (tx_fire) begin
                    go = 1'b1;
                    st_d = ST_HDR;
                end
            end
        endcase
        // Load the outgoing byte on entry to the echo or a status-byte state
        if (go) begin
            tx_vld_d = st_d inside {ST_ECHO, ST_SW1, ST_SW2};
            tx_byte_d = (st_d == ST_ECHO) ? hdr_d.ins : (st_d == ST_SW1) ? sw_d.sw1 : sw_d.sw2;
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (!I_NRST || life_d == CTE_LIFE_OFF) begin
            st_q <= ST_HDR;
            nxt_q <= ST_HDR;
            hdr_q <= '0;
            sw_q <= '0;
            hcnt_q <= CTE_HCNT_RST;
            cnt_q <= CTE_BYTE_RST;
            idx_q <= CTE_BYTE_RST;
            pend_len_q <= CTE_LEN_ZERO;
            pend_off_q <= CTE_LEN_ZERO;
            tx_vld_q <= 1'b0;
            tx_byte_q <= CTE_BYTE_RST;
            dat_q <= CTE_BYTE_RST;
            hdr_vld_q <= 1'b0;
            dat_vld_q <= 1'b0;
        end else begin
            st_q <= st_d;
            nxt_q <= nxt_d;
            hdr_q <= hdr_d;
            sw_q <= sw_d;
            hcnt_q <= hcnt_d;
            cnt_q <= cnt_d;
            idx_q <= idx_d;
            pend_len_q <= pend_len_d;
            pend_off_q <= pend_off_d;
            tx_vld_q <= tx_vld_d;
            tx_byte_q <= tx_byte_d;
            dat_q <= dat_d;
            hdr_vld_q <= hdr_vld_d;
            dat_vld_q <= dat_vld_d;
        end
    end

    assign O_CRD_VALID = tx_vld_q;
    assign O_CRD_BYTE = tx_byte_q;
    assign O_HDR_VALID = hdr_vld_q;
    assign O_HDR = hdr_q;
    assign O_DAT_VALID = dat_vld_q;
    assign O_DAT_BYTE = dat_q;
    assign O_RD_IDX = idx_q;
    assign O_LIFE = life_q;
    assign O_PEND_LEN = pend_len_q;

    // Checks
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);

    sequence s_sends(logic [7:0] b);
        O_CRD_VALID && O_CRD_BYTE == b;
    endsequence

    property p_off_quiet;
        life_q == CTE_LIFE_OFF |-> !O_TRM_READY && !O_HDR_VALID && !O_CRD_VALID;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("activity while inactive");
    property p_mgmt_entry;
        life_q != CTE_LIFE_OFF && pwr_s && I_APP_SEL_REQ |=> life_q == CTE_LIFE_MGMT;
    endproperty
    a_mgmt_entry: assert property (p_mgmt_entry) else $error("management not entered");
    property p_oper_entry;
        life_q == CTE_LIFE_MGMT ##1 life_q == CTE_LIFE_OPER |-> $past(sess_q) && $past(I_PIN_ALL_OK);
    endproperty
    a_oper_entry: assert property (p_oper_entry) else $error("operation without session");
    property p_status_only;
        st_q == ST_ANS && I_ANS_VALID && I_ANS.act == CTE_ACT_STATUS
            |=> s_sends($past(I_ANS.sw.sw1)) ##1 !O_DAT_VALID && st_q != ST_TXD;
    endproperty
    a_status_only: assert property (p_status_only) else $error("status reply wrong");
    property p_relen;
        st_q == ST_ANS && I_ANS_VALID && I_ANS.act == CTE_ACT_RELEN |=> s_sends(CTE_PB_RELEN);
    endproperty
    a_relen: assert property (p_relen) else $error("6C not sent");
    property p_echo_first;
        $rose(st_q == ST_RXD) |-> $past(st_q == ST_ECHO && tx_fire);
    endproperty
    a_echo_first: assert property (p_echo_first) else $error("data taken before echo");
    property p_more;
        st_q == ST_DONE && I_ANS_VALID && I_ANS.len != CTE_LEN_ZERO
            && I_ANS.sw.sw1 != CTE_SW1_WARN |=> s_sends(CTE_PB_MORE);
    endproperty
    a_more: assert property (p_more) else $error("61 not announced");
    property p_gr_echo;
        gr_take && !gr_relen |=> s_sends(CTE_GR_INS) ##0 nxt_q == ST_TXD;
    endproperty
    a_gr_echo: assert property (p_gr_echo) else $error("C0 not echoed");
    property p_gr_remain;
        gr_take && !gr_relen && I_TRM_BYTE < pend_len_q
            |=> pend_len_q == $past(pend_len_q) - $past(I_TRM_BYTE) && sw_q.sw1 == CTE_PB_MORE;
    endproperty
    a_gr_remain: assert property (p_gr_remain) else $error("remainder wrong");
    property p_gr_zero;
        gr_take && I_TRM_BYTE == CTE_LEN_ZERO
            |=> s_sends(CTE_PB_RELEN) ##0 sw_q.sw2 == $past(pend_len_q);
    endproperty
    a_gr_zero: assert property (p_gr_zero) else $error("zero fetch not 6C");
    property p_pend_kept;
        pend_len_q != CTE_LEN_ZERO && !hdr_last && life_d != CTE_LIFE_OFF
            && st_q != ST_DONE |=> pend_len_q == $past(pend_len_q);
    endproperty
    a_pend_kept: assert property (p_pend_kept) else $error("pending data lost");
endmodule : cte_seq

/* dv/cte_card_model.sv */
// Card logic stand-in: answers headers and supplies response bytes
`timescale 1ns/1ps
module cte_card_model
    import cte_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic i_hdr_valid,
    input wire cte_hdr_type i_hdr,
    input wire logic i_dat_valid,
    input wire logic [7:0] i_rd_idx,
    input wire cte_ans_type i_first,
    input wire cte_ans_type i_second,
    input wire logic i_slow,
    output logic o_ans_valid,
    output cte_ans_type o_ans,
    output logic [7:0] o_rd_byte
);
    logic [2:0] wait_q;
    logic [7:0] left_q;
    cte_ans_type pick_q;
    // Response byte store
    assign o_rd_byte = i_rd_idx ^ 8'ha5;
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            wait_q <= 3'h0;
            left_q <= 8'h00;
            o_ans_valid <= 1'b0;
            o_ans <= '0;
            pick_q <= '0;
        end else begin
            o_ans_valid <= 1'b0;
            o_ans <= cte_ans_type'(~o_ans);
            if (i_hdr_valid) begin
                wait_q <= i_slow ? 3'h6 : 3'h1;
                pick_q <= i_first;
                left_q <= (i_first.act == CTE_ACT_TAKE) ? i_hdr.p3 : 8'h00;
            end else if (i_dat_valid && left_q == 8'h01) begin
                wait_q <= i_slow ? 3'h6 : 3'h1;
                pick_q <= i_second;
                left_q <= 8'h00;
            end else if (i_dat_valid) begin
                left_q <= left_q - 8'h01;
            end else if (wait_q != 3'h0) begin
                wait_q <= wait_q - 3'h1;
                if (wait_q == 3'h1) begin
                    o_ans_valid <= 1'b1;
                    o_ans <= pick_q;
                end
            end
        end
    end
endmodule : cte_card_model

/* dv/cte_seq_tb.sv */
// Self-checking bench for the T=0 command sequencer
`timescale 1ns/1ps
module cte_seq_tb
    import cte_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic pwr_on = 1'b0;
    logic sess_ok = 1'b0;
    logic app_sel = 1'b0;
    logic pin_ok = 1'b0;
    logic trm_valid = 1'b0;
    logic [7:0] trm_byte = 8'h00;
    logic crd_ready = 1'b0;
    logic slow = 1'b0;
    cte_ans_type first = '0;
    cte_ans_type second = '0;
    cte_ans_type nil = '0;
    cte_ans_type ans;
    cte_hdr_type hdr;
    cte_hdr_type hdr_exp = '0;
    cte_life_type life;
    logic trm_ready, crd_valid, hdr_valid, ans_valid, dat_valid;
    logic [7:0] crd_byte, dat_byte, rd_idx, rd_byte, pend_len, r, ins, n, y, w;
    logic [7:0] exp_q[$];
    logic [7:0] dat_q[$];
    logic [31:0] seed = 32'h66eabc1a;
    logic [31:0] rdy_seed = 32'h66eabc1a;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    cte_seq uut (.I_CORE_CLK(clk), .I_NRST(nrst), .I_PWR_ON(pwr_on), .I_SESS_OK(sess_ok),
        .I_APP_SEL_REQ(app_sel), .I_PIN_ALL_OK(pin_ok), .I_TRM_VALID(trm_valid),
        .I_TRM_BYTE(trm_byte), .O_TRM_READY(trm_ready), .O_CRD_VALID(crd_valid),
        .O_CRD_BYTE(crd_byte), .I_CRD_READY(crd_ready), .O_HDR_VALID(hdr_valid), .O_HDR(hdr),
        .I_ANS_VALID(ans_valid), .I_ANS(ans), .O_DAT_VALID(dat_valid), .O_DAT_BYTE(dat_byte),
        .O_RD_IDX(rd_idx), .I_RD_BYTE(rd_byte), .O_LIFE(life), .O_PEND_LEN(pend_len));
    cte_card_model card (.i_clk(clk), .i_nrst(nrst), .i_hdr_valid(hdr_valid), .i_hdr(hdr),
        .i_dat_valid(dat_valid), .i_rd_idx(rd_idx), .i_first(first), .i_second(second),
        .i_slow(slow), .o_ans_valid(ans_valid), .o_ans(ans), .o_rd_byte(rd_byte));

    initial forever #2.5 clk = ~clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next
    function automatic cte_ans_type mk(cte_act_type a, logic [7:0] s1, s2, l);
        return '{a, '{s1, s2}, l};
    endfunction : mk
    task automatic rnd(output logic [7:0] v);
        seed = lfsr_next(seed);
        v = seed[7:0];
    endtask : rnd
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done();
        $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : test_done
    task automatic expb(input logic [7:0] b);
        exp_q.push_back(b);
    endtask : expb
    task automatic expd(input logic [7:0] off, input logic [7:0] cnt);
        for (int i = 0; i < cnt; i++) expb((off + 8'(i)) ^ 8'ha5);
    endtask : expd
    // Terminal byte stream, valid held until taken
    task automatic send(input logic [7:0] q[$]);
        @(posedge clk);
        trm_valid <= 1'b1;
        foreach (q[i]) begin
            trm_byte <= q[i];
            @(negedge clk);
            while (trm_ready !== 1'b1) @(negedge clk);
            @(posedge clk);
        end
        trm_valid <= 1'b0;
    endtask : send
    task automatic run_cmd(input cte_hdr_type h, input cte_ans_type a1, input cte_ans_type a2);
        logic [7:0] q[$];
        logic [7:0] b;
        first <= a1;
        second <= a2;
        slow <= seed[4];
        hdr_exp = h;
        send({h.cla, h.ins, h.p1, h.p2, h.p3});
        if (a1.act == CTE_ACT_TAKE) begin
            for (int i = 0; i < h.p3; i++) begin
                rnd(b);
                q.push_back(b);
                dat_q.push_back(b);
            end
            @(negedge clk);
            while (trm_ready !== 1'b1) @(negedge clk);
            send(q);
        end
        while (exp_q.size() != 0 || dat_q.size() != 0) @(posedge clk);
        repeat (2) @(posedge clk);
    endtask : run_cmd
    task automatic gr(input logic [7:0] le);
        run_cmd('{CTE_GR_CLA, CTE_GR_INS, CTE_GR_PAR, CTE_GR_PAR, le},
            mk(CTE_ACT_STATUS, CTE_SW1_OK, CTE_SW2_OK, 8'h00), nil);
    endtask : gr
    task automatic pend(input logic [7:0] s1, input logic [7:0] s2, input logic [7:0] cnt);
        expb(8'h24);
        expb(s1 == CTE_SW1_WARN || cnt == 8'h00 ? s1 : CTE_PB_MORE);
        expb(s1 == CTE_SW1_WARN || cnt == 8'h00 ? s2 : cnt);
        run_cmd('{8'h80, 8'h24, 8'h00, 8'h00, 8'h02}, mk(CTE_ACT_TAKE, 8'h00, 8'h00, 8'h00),
            mk(CTE_ACT_STATUS, s1, s2, cnt));
    endtask : pend

    // Outgoing byte and command data monitor, stalls and timeout
    always @(posedge clk) begin
        rdy_seed = lfsr_next(rdy_seed);
        crd_ready <= rdy_seed[1:0] != 2'b00;
        cycles++;
        if (crd_valid === 1'b1 && crd_ready === 1'b1)
            chk(crd_byte, exp_q.size() != 0 ? exp_q.pop_front() : ~crd_byte);
        if (dat_valid === 1'b1)
            chk(dat_byte, dat_q.size() != 0 ? dat_q.pop_front() : ~dat_byte);
        if (hdr_valid === 1'b1) begin
            chk(hdr.ins, hdr_exp.ins);
            chk(hdr.p3, hdr_exp.p3);
        end
        if (cycles == 20000) begin
            err_count++;
            $display("CHECK FAILED %0t timeout", $time);
            test_done();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        chk(8'(life), 8'(CTE_LIFE_OFF));
        chk({7'h00, trm_ready}, 8'h00);
        pwr_on <= 1'b1;
        pin_ok <= 1'b1;
        repeat (6) @(posedge clk);
        chk(8'(life), 8'(CTE_LIFE_MGMT));
        sess_ok <= 1'b1;
        @(posedge clk);
        sess_ok <= 1'b0;
        repeat (4) @(posedge clk);
        chk(8'(life), 8'(CTE_LIFE_OPER));
        app_sel <= 1'b1;
        pin_ok <= 1'b0;
        repeat (4) @(posedge clk);
        chk(8'(life), 8'(CTE_LIFE_MGMT));
        app_sel <= 1'b0;
        repeat (4) @(posedge clk);
        chk(8'(life), 8'(CTE_LIFE_MGMT));
        pin_ok <= 1'b1;
        repeat (4) @(posedge clk);
        chk(8'(life), 8'(CTE_LIFE_OPER));
        // No-data command, then wrong length and resend
        rnd(r);
        ins = {1'b0, r[6:0]};
        expb(CTE_SW1_OK);
        expb(CTE_SW2_OK);
        run_cmd('{8'h80, ins, r, 8'h00, CTE_LEN_ZERO},
            mk(CTE_ACT_STATUS, CTE_SW1_OK, CTE_SW2_OK, 8'h00), nil);
        n = {4'h0, r[3:0]} + 8'h01;
        expb(CTE_PB_RELEN);
        expb(n);
        run_cmd('{8'h80, ins, 8'h01, 8'h02, CTE_LEN_ZERO}, mk(CTE_ACT_RELEN, 8'h00, 8'h00, n),
            nil);
        expb(ins);
        expd(8'h00, n);
        expb(CTE_SW1_OK);
        expb(CTE_SW2_OK);
        run_cmd('{8'h80, ins, 8'h01, 8'h02, n},
            mk(CTE_ACT_SEND, CTE_SW1_OK, CTE_SW2_OK, 8'h00), nil);
        // Data in, split fetch of pending response
        rnd(r);
        n = {5'h00, r[2:0]} + 8'h05;
        y = {6'h00, r[4:3]} + 8'h01;
        pend(CTE_SW1_OK, CTE_SW2_OK, 8'h00);
        pend(CTE_SW1_OK, CTE_SW2_OK, n);
        chk(pend_len, n);
        repeat (20) @(posedge clk);
        chk(pend_len, n);
        expb(CTE_GR_INS);
        expd(8'h00, y);
        expb(CTE_PB_MORE);
        expb(n - y);
        gr(y);
        chk(pend_len, n - y);
        expb(CTE_GR_INS);
        expd(y, n - y);
        expb(CTE_SW1_OK);
        expb(CTE_SW2_OK);
        gr(n - y);
        chk(pend_len, 8'h00);
        // Warning, zero-length fetch, oversize fetch
        rnd(w);
        pend(CTE_SW1_WARN, w, n);
        expb(CTE_PB_RELEN);
        expb(n);
        gr(CTE_LEN_ZERO);
        expb(CTE_PB_RELEN);
        expb(n);
        gr(n + 8'h01);
        expb(CTE_GR_INS);
        expd(8'h00, n);
        expb(CTE_SW1_OK);
        expb(CTE_SW2_OK);
        gr(n);
        // New header drops pending response
        pend(CTE_SW1_OK, CTE_SW2_OK, n);
        expb(CTE_SW1_OK);
        expb(CTE_SW2_OK);
        run_cmd('{8'h80, ins, 8'h00, 8'h00, CTE_LEN_ZERO},
            mk(CTE_ACT_STATUS, CTE_SW1_OK, CTE_SW2_OK, 8'h00), nil);
        chk(pend_len, 8'h00);
        expb(CTE_SW1_OK);
        expb(CTE_SW2_OK);
        gr(8'h03);
        pwr_on <= 1'b0;
        repeat (6) @(posedge clk);
        chk(8'(life), 8'(CTE_LIFE_OFF));
        chk({7'h00, trm_ready}, 8'h00);
        test_done();
    end
endmodule : cte_seq_tb
